// ### bus_master_model.sv
/*
 * Processor bus master and higher chain neighbour, seen from the block.
 * Assumes one clock; pins change on the falling edge only.
 */
`timescale 1ns/1ps

module bus_master_model (
	// Clock.
	input wire logic clock,
	// Pins towards the block.
	output logic cs_n,
	output logic data_strobe_n,
	output logic rw,
	output logic [4:0] register_select,
	output logic int_ack_n,
	output logic chain_enable_in_n,
	output logic [7:0] data_bus_in,
	// Pins from the block.
	input wire logic [7:0] data_bus_out,
	input wire logic data_bus_oe,
	input wire logic transfer_ack_n,
	input wire logic transfer_ack_oe,
	input wire logic chain_enable_out_n
);
	logic drive = 1'b0;
	logic [7:0] drive_val = 8'h00;
	logic [7:0] last = 8'h00;
	logic ack_w;

	// ==========================================================
	// Wire resolution
	// ==========================================================
	// A floating data bus holds the inverse of the last level driven on it.
	assign data_bus_in = data_bus_oe ? data_bus_out : (drive ? drive_val : ~last);
	// The acknowledge line is pulled up while floating.
	assign ack_w = transfer_ack_oe ? transfer_ack_n : 1'b1;
	always @(posedge clock) if (data_bus_oe || drive) last <= data_bus_in;

	initial begin
		cs_n = 1'b1;
		data_strobe_n = 1'b1;
		rw = 1'b1;
		register_select = 5'h00;
		int_ack_n = 1'b1;
		chain_enable_in_n = 1'b0;
	end

	// ==========================================================
	// One bus or acknowledge cycle
	// ==========================================================
	// Ok means acknowledged, then driven high once and floated in time.
	task automatic cycle(input logic is_ack, input logic wr, input logic [4:0] idx,
		input logic [7:0] wdata, output logic [7:0] rdata, output logic ok,
		output logic passed);
		int n;
		logic got;
		logic high;
		begin
			got = 1'b0;
			high = 1'b0;
			passed = 1'b0;
			rdata = 8'h00;
			@(negedge clock);
			rw = !wr;
			register_select = idx;
			drive_val = wdata;
			drive = wr;
			// Qualifiers settle a cycle before the strobe.
			cs_n = is_ack;
			int_ack_n = !is_ack;
			@(negedge clock);
			data_strobe_n = 1'b0;
			for (n = 0; n < 12 && !got; n++) begin
				@(posedge clock);
				if (chain_enable_out_n === 1'b0 && data_bus_oe !== 1'b1) passed = 1'b1;
				if (ack_w === 1'b0) begin
					got = 1'b1;
					rdata = data_bus_in;
				end
			end
			// Data are latched, only then the strobe goes.
			@(negedge clock);
			data_strobe_n = 1'b1;
			cs_n = 1'b1;
			int_ack_n = 1'b1;
			drive = 1'b0;
			for (n = 0; n < 12 && transfer_ack_oe !== 1'b0; n++) begin
				@(posedge clock);
				if (transfer_ack_oe === 1'b1 && transfer_ack_n === 1'b1) high = 1'b1;
			end
			ok = got && high && data_bus_oe === 1'b0 && transfer_ack_oe === 1'b0;
			repeat (3) @(negedge clock);
		end
	endtask

	// The higher chain neighbour changes its enable between cycles only.
	task automatic set_chain_in(input logic level);
		chain_enable_in_n = level;
	endtask
endmodule // bus_master_model

// ### host_bus_and_vectored_interrupt_tb.sv
/*
 * Self-checking bench for the host bus and vectored interrupt block.
 * Assumes the bus master model drives the bus pins.
 */
`timescale 1ns/1ps

`include "host_bus_cfg.svh"

module host_bus_and_vectored_interrupt_tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [15:0] channel_event = 16'h0000;
	logic cs_n, data_strobe_n, rw, int_ack_n, chain_enable_in_n;
	logic [4:0] register_select;
	logic [7:0] data_bus_in, data_bus_out, port_dir, v;
	logic data_bus_oe, transfer_ack_n, transfer_ack_oe, irq_n, chain_enable_out_n;
	logic ok, passed;
	int miscompares = 0;
	int comparisons = 0;

	// ==========================================================
	// Clock, block and bus master
	// ==========================================================
	initial forever #12.5 clock = ~clock;

	host_bus_irq u_dut (.clock(clock), .rst(rst), .cs_n(cs_n), .data_strobe_n(data_strobe_n),
		.rw(rw), .register_select(register_select), .int_ack_n(int_ack_n),
		.data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
		.transfer_ack_n(transfer_ack_n), .transfer_ack_oe(transfer_ack_oe), .irq_n(irq_n),
		.chain_enable_in_n(chain_enable_in_n), .chain_enable_out_n(chain_enable_out_n),
		.channel_event(channel_event), .port_dir(port_dir));

	bus_master_model u_master (.clock(clock), .cs_n(cs_n), .data_strobe_n(data_strobe_n),
		.rw(rw), .register_select(register_select), .int_ack_n(int_ack_n),
		.chain_enable_in_n(chain_enable_in_n), .data_bus_in(data_bus_in),
		.data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
		.transfer_ack_n(transfer_ack_n), .transfer_ack_oe(transfer_ack_oe),
		.chain_enable_out_n(chain_enable_out_n));

	// ==========================================================
	// Shared tasks
	// ==========================================================
	// Compares and counts; a mismatch is reported at once.
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// A handshake that ran out of its bound ends the run.
	task automatic need(input logic good);
		check("handshake", good, 1'b1);
		if (good !== 1'b1) conclude();
	endtask

	task automatic wr(input logic [4:0] idx, input logic [7:0] d);
		u_master.cycle(1'b0, 1'b1, idx, d, v, ok, passed);
		need(ok);
	endtask

	task automatic rd(input logic [4:0] idx, input logic [7:0] exp);
		u_master.cycle(1'b0, 1'b0, idx, 8'h00, v, ok, passed);
		need(ok);
		check("read data", v, exp);
	endtask

	task automatic ack();
		u_master.cycle(1'b1, 1'b0, 5'h00, 8'h00, v, ok, passed);
	endtask

	task automatic pulse(input logic [15:0] bits);
		@(negedge clock);
		channel_event = bits;
		@(negedge clock);
		channel_event = 16'h0000;
		repeat (3) @(negedge clock);
	endtask

	task automatic open_all();
		wr(5'h03, 8'hFF);
		wr(5'h04, 8'hFF);
		wr(5'h09, 8'hFF);
		wr(5'h0A, 8'hFF);
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic t_reset();
		check("irq_n", irq_n, 1'b1);
		check("port_dir", port_dir, 8'h00);
		check("chain out", chain_enable_out_n, 1'b1);
		rd(5'h05, 8'h00);
		rd(5'h06, 8'h00);
		ack();
		check("pass ack", ok, 1'b0);
		check("pass chain", passed, 1'b1);
	endtask

	task automatic t_regs();
		wr(5'h02, 8'hA5);
		check("port_dir", port_dir, 8'hA5);
		rd(5'h02, 8'hA5);
		wr(5'h1F, 8'h3C);
		rd(5'h1F, 8'h3C);
	endtask

	task automatic t_codes();
		open_all();
		wr(5'h0B, 8'h40);
		for (int i = 0; i < 16; i++) begin
			pulse(16'h0001 << i);
			check("irq_n raised", irq_n, 1'b0);
			ack();
			need(ok);
			check("no pass", passed, 1'b0);
			check("vector", v, {4'h4, 4'(i)});
			check("irq_n dropped", irq_n, 1'b1);
		end
	endtask

	task automatic t_prio();
		u_master.set_chain_in(1'b1);
		pulse(16'hA001);
		ack();
		check("blocked ack", ok, 1'b0);
		check("blocked pass", passed, 1'b0);
		u_master.set_chain_in(1'b0);
		ack();
		need(ok);
		check("vector", v, 8'h4F);
		rd(5'h05, 8'h20);
		check("irq_n kept", irq_n, 1'b0);
		ack();
		need(ok);
		check("vector", v, 8'h4D);
		ack();
		need(ok);
		check("vector", v, 8'h40);
		check("irq_n", irq_n, 1'b1);
	endtask

	task automatic t_mask();
		wr(5'h09, 8'h7F);
		pulse(16'h8100);
		ack();
		need(ok);
		check("vector", v, 8'h48);
		check("irq_n masked", irq_n, 1'b1);
		rd(5'h05, 8'h80);
		wr(5'h05, 8'h00);
		rd(5'h05, 8'h00);
		wr(5'h09, 8'hFF);
		check("irq_n", irq_n, 1'b1);
	endtask

	task automatic t_midreset();
		pulse(16'h0008);
		check("irq_n", irq_n, 1'b0);
		@(negedge clock);
		rst = 1'b1;
		repeat (`RESET_HOLD_CYCLES) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		check("irq_n", irq_n, 1'b1);
		check("port_dir", port_dir, 8'h00);
		rd(5'h1F, 8'h3C);
		pulse(16'h0008);
		rd(5'h06, 8'h00);
		open_all();
		pulse(16'h0008);
		ack();
		need(ok);
		check("vector", v, 8'h03);
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		repeat (6) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		t_reset();
		t_regs();
		t_codes();
		t_prio();
		t_mask();
		t_midreset();
		conclude();
	end
endmodule // host_bus_and_vectored_interrupt_tb

// ### host_bus_cfg.svh
/*
 * Constants for the host bus and vectored interrupt block: register
 * indices on the register select lines, reset values and timing figures.
 * Assumes it is included by bare name from the design and bench files.
 */
`ifndef HOST_BUS_CFG_SVH
`define HOST_BUS_CFG_SVH

// ==========================================================
// Register indices seen on the register select lines
// ==========================================================
`define IDX_PORT_DIR 5'h02
`define IDX_ENABLE_A 5'h03
`define IDX_ENABLE_B 5'h04
`define IDX_PENDING_A 5'h05
`define IDX_PENDING_B 5'h06
`define IDX_SERVICE_A 5'h07
`define IDX_SERVICE_B 5'h08
`define IDX_MASK_A 5'h09
`define IDX_MASK_B 5'h0A
`define IDX_VECTOR 5'h0B

// ==========================================================
// Field positions and reset values
// ==========================================================
`define VEC_BASE_MSB 7
`define VEC_BASE_LSB 4
`define VEC_SERVICE_BIT 3
`define VECTOR_RESET 8'h0F
`define BYTE_ZERO 8'h00
`define CHANNELS_ZERO 16'h0000

// ==========================================================
// Timing
// ==========================================================
`define CLOCK_PERIOD_NS 25
`define RESET_HOLD_NS 2000
`define RESET_HOLD_CYCLES ((`RESET_HOLD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// ### host_bus_irq.sv
/*
 * Host bus slave and vectored interrupt responder: register reads and
 * writes over the asynchronous byte bus, 16 fixed-priority channels,
 * vector answer in acknowledge cycles and the enable daisy chain.
 * Assumes channel events are one-cycle pulses on this clock and that the
 * bus pins are asynchronous and pass the synchroniser below.
 */
// What this block does
// - Read drives selected register, then acknowledges.
// - Read ends: acknowledge high, then bus released.
// - Write loads addressed register, then acknowledges.
// - Write ends: acknowledge high, then floated.
// - Request output low while any unmasked channel pending.
// - Acknowledge cycle places vector, then acknowledges.
// - Acknowledge cycle ends: acknowledge high, then floated.
// - Request drops after acknowledge unless more pending.
// - Chain enabled: answer if unmasked pending, else pass down.
// - Passing device drives no data nor acknowledge.
// - Chain out only when nothing here or above.
// - Reset clears registers except retained data and vector registers.
// - Reset disables channels and clears pending interrupts.
// - Reset makes port lines inputs, outputs negated.
// - Reset loads vector register with 0F hex.
// - Vector names highest priority pending channel.
// - Channel codes descend from port line seven.
// - Masked channels are skipped in priority order.
// - Vector upper nibble from register, lower channel.
// - Passed channel's pending bit is cleared.
`timescale 1ns/1ps

`include "host_bus_cfg.svh"

module host_bus_irq import host_bus_pkg::*; #(
	parameter int CHANNELS = 16,
	parameter int REG_DEPTH = 32
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Bus controls from the bus master.
	input wire logic cs_n,
	input wire logic data_strobe_n,
	input wire logic rw,
	input wire logic [4:0] register_select,
	input wire logic int_ack_n,
	// Data bus as input, output and output enable.
	input wire logic [7:0] data_bus_in,
	output logic [7:0] data_bus_out,
	output logic data_bus_oe,
	// Transfer acknowledge as output and output enable.
	output logic transfer_ack_n,
	output logic transfer_ack_oe,
	// Interrupt request and daisy chain.
	output logic irq_n,
	input wire logic chain_enable_in_n,
	output logic chain_enable_out_n,
	// Channel events from the timers, serial unit and port edge detectors.
	input wire logic [15:0] channel_event,
	// Port line direction towards the port logic, high drives a line.
	output logic [7:0] port_dir
);

	// ==========================================================
	// Declarations
	// ==========================================================
	bus_pins_t pins_meta;
	bus_pins_t pins;
	bus_state_t state;
	logic [15:0] enable;
	logic [15:0] pending;
	logic [15:0] mask;
	logic [7:0] vector_reg;
	logic [15:0] active;
	logic [15:0] clear_vec;
	logic any_active;
	logic [3:0] top_code;
	logic strobe_on;
	logic cycle_on;
	logic int_ack_n_on;
	logic take_write;
	logic take_read;
	logic take_int_ack_n;
	logic take_pass;
	logic store_we;
	logic [7:0] store_rdata;

	// Channel count and register space are fixed by the vector format.
	initial begin
		if (CHANNELS != 16 || REG_DEPTH != 32) begin
			$error("host_bus_irq: only 16 channels and 32 registers are served");
		end
	end

	// ==========================================================
	// Functions
	// ==========================================================
	// Bit i of a channel vector is the channel whose code is i, so bit 15 is
	// port line 7 and bit 0 is port line 0; the highest set bit wins.
	function automatic logic [3:0] highest_code(input logic [15:0] req);
		logic [3:0] code;
		code = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (req[i]) begin
				code = 4'(i);
			end
		end
		return code;
	endfunction

	// Registers kept in flip-flops, or read as zero (service), rather than in the retained store.
	function automatic logic is_control(input logic [4:0] idx);
		return idx inside {`IDX_PORT_DIR, `IDX_ENABLE_A, `IDX_ENABLE_B,
			`IDX_PENDING_A, `IDX_PENDING_B, `IDX_SERVICE_A, `IDX_SERVICE_B,
			`IDX_MASK_A, `IDX_MASK_B, `IDX_VECTOR};
	endfunction

	// ==========================================================
	// Input synchroniser
	// ==========================================================
	// All bus pins pass two flops together; the master's deskew keeps select,
	// direction and data settled before the strobe arrives.
	always_ff @(posedge clock) begin
		pins_meta <= {cs_n, data_strobe_n, int_ack_n, chain_enable_in_n, rw,
			register_select, data_bus_in};
		pins <= pins_meta;
	end

	// ==========================================================
	// Cycle decode
	// ==========================================================
	// Qualified requests are taken only from the idle state.
	assign strobe_on = !pins.data_strobe_n;
	assign int_ack_n_on = !pins.int_ack_n && strobe_on;
	assign cycle_on = !pins.cs_n && strobe_on && pins.int_ack_n;
	assign take_write = (state == S_IDLE) && cycle_on && !pins.rw;
	assign take_read = (state == S_IDLE) && cycle_on && pins.rw;
	assign take_int_ack_n = (state == S_IDLE) && int_ack_n_on && !pins.chain_enable_in_n
		&& any_active;
	assign take_pass = (state == S_IDLE) && int_ack_n_on && !pins.chain_enable_in_n
		&& !any_active;
	assign store_we = take_write && !is_control(pins.register_select);

	// Masked channels drop out before ranking.
	assign active = pending & mask;
	assign any_active = |active;
	assign top_code = highest_code(active);

	// ==========================================================
	// Retained register store
	// ==========================================================
	register_store #(
		.WIDTH(8),
		.DEPTH(REG_DEPTH),
		.ADDR_BITS(5)
	) u_store (
		.clock(clock),
		.write_en(store_we),
		.write_addr(pins.register_select),
		.write_data(pins.data_bus),
		.read_addr(pins.register_select),
		.read_data(store_rdata)
	);

	// ==========================================================
	// Bus cycle sequencer
	// ==========================================================
	// Reads wait one clock for the store; every answer holds until the
	// master drops chip select, the strobe or acknowledge.
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= S_IDLE;
		end else begin
			unique case (state)
				S_IDLE: begin
					if (take_read) begin
						state <= S_READ;
					end else if (take_write || take_int_ack_n) begin
						state <= S_ACK;
					end else if (take_pass) begin
						state <= S_PASS;
					end
				end
				S_READ: state <= S_ACK;
				S_ACK: begin
					// The master latches data before it lets the strobe go.
					if (!(cycle_on || int_ack_n_on)) begin
						state <= S_END;
					end
				end
				S_END: state <= S_IDLE;
				S_PASS: begin
					if (!int_ack_n_on) begin
						state <= S_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Data bus drive
	// ==========================================================
	// Read data and vectors are placed in the same clock as the acknowledge falls.
	always_ff @(posedge clock) begin
		if (rst) begin
			data_bus_out <= `BYTE_ZERO;
			data_bus_oe <= 1'b0;
		end else if (take_int_ack_n) begin
			data_bus_out <= {vector_reg[`VEC_BASE_MSB:`VEC_BASE_LSB], top_code};
			data_bus_oe <= 1'b1;
		end else if (state == S_READ) begin
			data_bus_oe <= 1'b1;
			unique case (pins.register_select)
				`IDX_PORT_DIR: data_bus_out <= port_dir;
				`IDX_ENABLE_A: data_bus_out <= enable[15:8];
				`IDX_ENABLE_B: data_bus_out <= enable[7:0];
				`IDX_PENDING_A: data_bus_out <= pending[15:8];
				`IDX_PENDING_B: data_bus_out <= pending[7:0];
				`IDX_MASK_A: data_bus_out <= mask[15:8];
				`IDX_MASK_B: data_bus_out <= mask[7:0];
				`IDX_VECTOR: data_bus_out <= vector_reg;
				`IDX_SERVICE_A, `IDX_SERVICE_B: data_bus_out <= `BYTE_ZERO;
				default: data_bus_out <= store_rdata;
			endcase
		end else if (state == S_END || state == S_IDLE) begin
			data_bus_oe <= 1'b0;
		end
	end

	// ==========================================================
	// Transfer acknowledge drive
	// ==========================================================
	// Low while answering, high for one clock at the end, then floated.
	always_ff @(posedge clock) begin
		if (rst) begin
			transfer_ack_n <= 1'b1;
			transfer_ack_oe <= 1'b0;
		end else begin
			unique case (state)
				S_IDLE: begin
					transfer_ack_n <= !(take_write || take_int_ack_n);
					transfer_ack_oe <= take_write || take_int_ack_n;
				end
				S_READ: begin
					transfer_ack_n <= 1'b0;
					transfer_ack_oe <= 1'b1;
				end
				S_ACK: begin
					transfer_ack_n <= cycle_on || int_ack_n_on ? 1'b0 : 1'b1;
					transfer_ack_oe <= 1'b1;
				end
				S_END: begin
					transfer_ack_n <= 1'b1;
					transfer_ack_oe <= 1'b0;
				end
				S_PASS: begin
					transfer_ack_n <= 1'b1;
					transfer_ack_oe <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Control registers
	// ==========================================================
	// Enable, mask, direction and vector registers, cleared by reset except
	// the vector register which starts at its fixed value.
	always_ff @(posedge clock) begin
		if (rst) begin
			enable <= `CHANNELS_ZERO;
			mask <= `CHANNELS_ZERO;
			port_dir <= `BYTE_ZERO;
			vector_reg <= `VECTOR_RESET;
		end else if (take_write) begin
			unique case (pins.register_select)
				`IDX_PORT_DIR: port_dir <= pins.data_bus;
				`IDX_ENABLE_A: enable[15:8] <= pins.data_bus;
				`IDX_ENABLE_B: enable[7:0] <= pins.data_bus;
				`IDX_MASK_A: mask[15:8] <= pins.data_bus;
				`IDX_MASK_B: mask[7:0] <= pins.data_bus;
				`IDX_VECTOR: vector_reg <= {pins.data_bus[7:3], 3'b000};
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Pending channels
	// ==========================================================
	// Writing zero to an enable or pending bit clears it; the passed vector
	// clears its own channel. A new event in the same clock wins.
	always_comb begin
		clear_vec = `CHANNELS_ZERO;
		if (take_write) begin
			unique case (pins.register_select)
				`IDX_ENABLE_A, `IDX_PENDING_A: clear_vec[15:8] = ~pins.data_bus;
				`IDX_ENABLE_B, `IDX_PENDING_B: clear_vec[7:0] = ~pins.data_bus;
				default: clear_vec = `CHANNELS_ZERO;
			endcase
		end
		if (take_int_ack_n) begin
			clear_vec[top_code] = 1'b1;
		end
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			pending <= `CHANNELS_ZERO;
		end else begin
			pending <= (pending & ~clear_vec) | (channel_event & enable);
		end
	end

	// ==========================================================
	// Interrupt request and daisy chain
	// ==========================================================
	// The request follows the unmasked pending set, so it rises after the
	// acknowledge clears the last one and stays low while others remain.
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_n <= 1'b1;
			chain_enable_out_n <= 1'b1;
		end else begin
			irq_n <= !any_active;
			chain_enable_out_n <= !(int_ack_n_on && !pins.chain_enable_in_n && !any_active
				&& state != S_ACK && state != S_READ);
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	read_answer_a: assert property (take_read |=> ##1 data_bus_oe && !transfer_ack_n && transfer_ack_oe)
		else $error("read answer missing");
	cycle_end_a: assert property (state == S_END |-> ##1 transfer_ack_n && !transfer_ack_oe && !data_bus_oe)
		else $error("bus not released after cycle end");
	end_high_a: assert property ((state == S_ACK && !(cycle_on || int_ack_n_on)) |=> transfer_ack_n && transfer_ack_oe)
		else $error("acknowledge not driven high at end");
	write_load_a: assert property (take_write && pins.register_select == `IDX_MASK_A |=> mask[15:8] == $past(pins.data_bus) ##1 !transfer_ack_n)
		else $error("write did not load register");
	irq_level_a: assert property ((any_active)[*2] |-> !irq_n)
		else $error("request not asserted while pending");
	irq_drop_a: assert property ((!any_active)[*2] |-> irq_n)
		else $error("request held with nothing pending");
	vector_value_a: assert property (take_int_ack_n |=> data_bus_out == {$past(vector_reg[7:4]), $past(top_code)} ##1 !transfer_ack_n)
		else $error("wrong vector presented");
	pend_clear_a: assert property (take_int_ack_n && !channel_event[top_code] |=> !pending[$past(top_code)])
		else $error("passed channel still pending");
	pass_quiet_a: assert property (state == S_PASS |-> !data_bus_oe && !transfer_ack_oe)
		else $error("passing device drives the bus");
	chain_out_a: assert property (!chain_enable_out_n |-> $past(!pins.chain_enable_in_n && !any_active))
		else $error("chain passed while requesting");
	vector_reset_a: assert property ($fell(rst) |-> vector_reg == `VECTOR_RESET)
		else $error("vector register not reset");

	read_cycle_c: cover property (take_read ##[1:20] state == S_END);
	write_cycle_c: cover property (take_write ##[1:20] state == S_END);
	int_ack_n_answer_c: cover property (take_int_ack_n ##[1:20] state == S_END);
	int_ack_n_pass_c: cover property (take_pass ##[1:20] !chain_enable_out_n);

endmodule // host_bus_irq

// ### host_bus_pkg.sv
/*
 * Types shared by the host bus block: bus cycle states and the bundle of
 * bus pins that crosses the input synchroniser together.
 * Assumes nothing of its surroundings.
 */
package host_bus_pkg;

	// ==========================================================
	// Bus cycle sequencer states
	// ==========================================================
	typedef enum logic [2:0] {
		S_IDLE,
		S_READ,
		S_ACK,
		S_END,
		S_PASS
	} bus_state_t;

	// ==========================================================
	// Bus pins sampled as one bundle
	// ==========================================================
	typedef struct packed {
		logic cs_n;
		logic data_strobe_n;
		logic int_ack_n;
		logic chain_enable_in_n;
		logic rw;
		logic [4:0] register_select;
		logic [7:0] data_bus;
	} bus_pins_t;

endpackage

// ### register_store.sv
/*
 * Small register memory for the byte registers that keep their contents
 * through reset. Read data come out of a register one clock after the
 * address. Assumes a single clock and no reset of the contents.
 */
`timescale 1ns/1ps

module register_store #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int ADDR_BITS = 5
) (
	// Clock.
	input wire logic clock,
	// Write port.
	input wire logic write_en,
	input wire logic [ADDR_BITS-1:0] write_addr,
	input wire logic [WIDTH-1:0] write_data,
	// Read port.
	input wire logic [ADDR_BITS-1:0] read_addr,
	output logic [WIDTH-1:0] read_data
);

	// ==========================================================
	// Storage
	// ==========================================================
	logic [WIDTH-1:0] cells [DEPTH];

	// Depth must fit the address width.
	initial begin
		if (DEPTH > (1 << ADDR_BITS) || WIDTH < 1) begin
			$error("register_store: depth does not fit address width");
		end
	end

	// Contents are deliberately not reset so that they survive a device reset.
	always_ff @(posedge clock) begin
		if (write_en) begin
			cells[write_addr] <= write_data;
		end
	end

	// Registered read keeps the read path a clean flip-flop output.
	always_ff @(posedge clock) begin
		read_data <= cells[read_addr];
	end

endmodule // register_store
